//--- acc_calib_regs.sv
// Control and calibration coefficient registers behind the serial port
// Operation
// - Upper or middle control write releases ready
// - Such write in calibration mode recalibrates first
// - Low control byte write leaves ready, calibration
// - 24-bit offset factor, self-cal after reset
// - Offset correction zeroes output at zero input
// - 24-bit positive slope, self-cal after reset
// - 24-bit negative slope, self-cal after reset
// - Gain in control bits 7..5, reset unity
// - Ready low marks valid result available
// - Reset selects self calibration mode
`default_nettype none
`include "acc_cfg.svh"
module acc_calib_regs
  import acc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic [23:0] raw_data,
  input wire logic raw_valid,
  output logic result_ready_n,
  output logic [2:0] gain_select,
  output var acc_phase_t cal_phase
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s1_q, s2_q;
  logic sclk_old_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Idle pin levels, so no false select or clock edge follows reset
      s1_q <= 3'h6;
      s2_q <= 3'h6;
      sclk_old_q <= 1'b1;
    end else begin
      s1_q <= {cs_n, sclk, sdio_in};
      s2_q <= s1_q;
      sclk_old_q <= s2_q[1];
    end
  end
  logic sel, rise, fall, sdi;
  assign sel = !s2_q[2];
  assign sdi = s2_q[0];
  assign rise = sel && s2_q[1] && !sclk_old_q;
  assign fall = sel && !s2_q[1] && sclk_old_q;

  // ----------------------------------------------------------------
  // Serial frame: instruction byte, then data bytes in descending order
  // ----------------------------------------------------------------
  logic [7:0] ins_q, ins_d, sh_q, sh_d, tx_q, tx_d;
  logic [2:0] bit_q, bit_d;
  logic [2:0] nby_q, nby_d;
  logic [1:0] idx_q, idx_d;
  logic have_ins_q, have_ins_d, oe_q, oe_d;
  logic byte_done, wr_byte, rd_last;
  logic [7:0] rx_byte, rd_byte;
  logic [2:0] adr;
  acc_ctl_t ctl_q, ctl_d;
  logic [23:0] dout_q, dout_d;
  logic [2:0][23:0] coef;
  logic [23:0] rd_word;

  assign rx_byte = {sh_q[6:0], sdi};
  assign byte_done = rise && (bit_q == 3'h7);
  assign adr = ins_q[`ACC_INS_ADR_HI:0];
  assign wr_byte = byte_done && have_ins_q && !ins_q[`ACC_INS_RD] && (nby_q != 3'h0);
  assign rd_last = byte_done && have_ins_q && ins_q[`ACC_INS_RD] && (nby_q == 3'h1);

  always_comb begin
    case (adr)
      `ACC_ADDR_DATA: rd_word = dout_q;
      `ACC_ADDR_CTL: rd_word = ctl_q;
      `ACC_ADDR_OFS: rd_word = coef[`ACC_W_OFS];
      `ACC_ADDR_POS: rd_word = coef[`ACC_W_POS];
      `ACC_ADDR_NEG: rd_word = coef[`ACC_W_NEG];
      default: rd_word = 24'h000000;
    endcase
    rd_byte = rd_word[idx_q*8 +: 8];
  end

  always_comb begin
    ins_d = ins_q;
    sh_d = sh_q;
    tx_d = tx_q;
    bit_d = bit_q;
    nby_d = nby_q;
    idx_d = idx_q;
    have_ins_d = have_ins_q;
    oe_d = oe_q;
    if (!sel) begin
      bit_d = 3'h0;
      have_ins_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      if (rise) begin
        sh_d = rx_byte;
        bit_d = bit_q + 3'h1;
      end
      if (byte_done && !have_ins_q) begin
        ins_d = rx_byte;
        have_ins_d = 1'b1;
        nby_d = {1'b0, rx_byte[`ACC_INS_CNT_HI:`ACC_INS_CNT_LO]} + 3'h1;
        idx_d = rx_byte[`ACC_INS_IDX_HI:`ACC_INS_IDX_LO];
      end else if (byte_done && nby_q != 3'h0) begin
        // Extra bytes beyond the count are ignored
        nby_d = nby_q - 3'h1;
        idx_d = idx_q - 2'h1;
      end
      if (fall) begin
        if (bit_q == 3'h0 && have_ins_q && ins_q[`ACC_INS_RD] && nby_q != 3'h0) begin
          tx_d = rd_byte;
          oe_d = 1'b1;
        end else begin
          tx_d = {tx_q[6:0], 1'b0};
          if (bit_q == 3'h0) begin
            oe_d = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ins_q <= 8'h00;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      bit_q <= 3'h0;
      nby_q <= 3'h0;
      idx_q <= 2'h0;
      have_ins_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      ins_q <= ins_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      bit_q <= bit_d;
      nby_q <= nby_d;
      idx_q <= idx_d;
      have_ins_q <= have_ins_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Control register, calibration sequencer, result path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACC_ST_ZERO, ACC_ST_POS, ACC_ST_NEG, ACC_ST_RUN} acc_st_t;
  acc_st_t st_q, st_d;
  logic rdy_n_q, rdy_n_d;
  logic [23:0] ctl_w;
  logic ctl_wr, ctl_hi_wr, coef_wr, is_cal;
  logic [24:0] diff;
  logic [49:0] prod, scaled;
  logic [23:0] slope, res;
  logic [24:0] span;
  acc_wr_t wr;

  assign ctl_wr = wr_byte && adr == `ACC_ADDR_CTL;
  assign ctl_hi_wr = ctl_wr && idx_q != `ACC_BYTE_LO;
  assign coef_wr = wr_byte && (adr == `ACC_ADDR_OFS || adr == `ACC_ADDR_POS
                               || adr == `ACC_ADDR_NEG);
  always_comb begin
    ctl_w = ctl_q;
    ctl_w[idx_q*8 +: 8] = rx_byte;
  end
  assign is_cal = ctl_w[11:9] == `ACC_MODE_SELF || ctl_w[11:9] == `ACC_MODE_SYS_OFS
                  || ctl_w[11:9] == `ACC_MODE_SYS_GAIN;

  // Offset first, then slope picked by the sign of the corrected sample
  assign diff = {raw_data[23], raw_data} - {coef[`ACC_W_OFS][23], coef[`ACC_W_OFS]};
  assign slope = diff[24] ? coef[`ACC_W_NEG] : coef[`ACC_W_POS];
  assign prod = 50'($signed(diff) * $signed({1'b0, slope}));
  assign scaled = 50'($signed(prod) >>> `ACC_COEF_SHIFT);
  always_comb begin
    if ($signed(scaled) > $signed({26'h0, `ACC_RES_MAX})) begin
      res = `ACC_RES_MAX;
    end else if ($signed(scaled) < $signed({26'h3ffffff, `ACC_RES_MIN})) begin
      res = `ACC_RES_MIN;
    end else begin
      res = scaled[23:0];
    end
  end
  // First-order gain correction: ideal span minus measured span
  assign span = 25'(`ACC_IDEAL_FS) - ({1'b0, diff[24] ? 24'(-diff) : diff[23:0]});

  always_comb begin
    st_d = st_q;
    ctl_d = ctl_q;
    rdy_n_d = rdy_n_q;
    dout_d = dout_q;
    wr = '0;
    if (rd_last && adr == `ACC_ADDR_DATA) begin
      rdy_n_d = 1'b1;
    end
    case (st_q)
      ACC_ST_ZERO: begin
        if (raw_valid) begin
          wr = '{en: 1'b1, word: `ACC_W_OFS, lanes: 3'h7, data: raw_data};
          st_d = ACC_ST_POS;
        end
      end
      ACC_ST_POS: begin
        if (raw_valid) begin
          wr = '{en: 1'b1, word: `ACC_W_POS, lanes: 3'h7,
                 data: `ACC_COEF_ONE + span[23:0]};
          st_d = ACC_ST_NEG;
        end
      end
      ACC_ST_NEG: begin
        if (raw_valid) begin
          wr = '{en: 1'b1, word: `ACC_W_NEG, lanes: 3'h7,
                 data: `ACC_COEF_ONE + span[23:0]};
          st_d = ACC_ST_RUN;
          ctl_d.operating_mode_field = `ACC_MODE_CONV;
        end
      end
      ACC_ST_RUN: begin
        if (raw_valid) begin
          dout_d = res;
          rdy_n_d = 1'b0;
        end
        if (coef_wr) begin
          wr = '{en: 1'b1, word: 2'(adr - `ACC_ADDR_OFS), lanes: 3'(1 << idx_q),
                 data: {3{rx_byte}}};
        end
      end
      default: st_d = ACC_ST_RUN;
    endcase
    if (ctl_wr) begin
      ctl_d = ctl_w;
    end
    if (ctl_hi_wr) begin
      rdy_n_d = 1'b1;
      st_d = is_cal ? ACC_ST_ZERO : ACC_ST_RUN;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ACC_ST_ZERO;
      ctl_q <= `ACC_CTL_RESET;
      rdy_n_q <= 1'b1;
      dout_q <= 24'h000000;
      gain_select <= `ACC_GAIN_UNITY;
      cal_phase <= ACC_PH_ZERO;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      rdy_n_q <= rdy_n_d;
      dout_q <= dout_d;
      gain_select <= ctl_d.gain_select;
      cal_phase <= st_d == ACC_ST_ZERO ? ACC_PH_ZERO : st_d == ACC_ST_POS ? ACC_PH_POS :
                   st_d == ACC_ST_NEG ? ACC_PH_NEG : ACC_PH_INPUT;
      sdio_out <= tx_d[7];
      sdio_oe <= oe_d;
    end
  end
  assign result_ready_n = rdy_n_q;

  acc_coef_mem u_mem (
    .mclk(mclk),
    .wr(wr),
    .rd_q(coef)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  rdy_hi_write_a: assert property (ctl_hi_wr |=> result_ready_n)
    else $error("ready not released by upper control write");
  recal_start_a: assert property (ctl_hi_wr && is_cal |=> st_q == ACC_ST_ZERO)
    else $error("calibration not restarted");
  lo_byte_keep_a: assert property (ctl_wr && idx_q == `ACC_BYTE_LO && st_q == ACC_ST_RUN
                                   && !raw_valid && !rd_last |=> $stable(result_ready_n)
                                   && st_q == ACC_ST_RUN)
    else $error("low control byte disturbed ready or calibration");
  cal_no_ready_a: assert property (st_q != ACC_ST_RUN && !raw_valid && result_ready_n
                                   |=> result_ready_n)
    else $error("ready asserted during calibration");
  ofs_cal_a: assert property (st_q == ACC_ST_ZERO && raw_valid && !ctl_hi_wr
                              |-> ##2 coef[`ACC_W_OFS] == $past(raw_data, 2))
    else $error("offset not captured");
  zero_out_a: assert property (st_q == ACC_ST_RUN && raw_valid && !ctl_hi_wr
                               && raw_data == coef[`ACC_W_OFS] |=> dout_q == 24'h000000)
    else $error("zero input not corrected to zero");
  pos_cal_a: assert property (st_q == ACC_ST_POS && raw_valid && !ctl_hi_wr
                              |=> st_q == ACC_ST_NEG ##1 coef[`ACC_W_POS] == $past(wr.data, 2))
    else $error("positive slope not stored");
  neg_cal_a: assert property (st_q == ACC_ST_NEG && raw_valid && !ctl_hi_wr
                              |=> st_q == ACC_ST_RUN
                              && ctl_q.operating_mode_field == `ACC_MODE_CONV)
    else $error("negative slope phase did not finish");
  gain_out_a: assert property (ctl_wr && idx_q == `ACC_BYTE_LO |=> gain_select == $past(rx_byte[7:5]))
    else $error("gain output differs from control field");
  rdy_low_a: assert property ($fell(result_ready_n) |-> $past(st_q) == ACC_ST_RUN
                              && $past(raw_valid))
    else $error("ready asserted without a result");
  coef_write_a: assert property (coef_wr && st_q == ACC_ST_RUN |-> ##2
                                 coef[$past(adr, 2) - `ACC_ADDR_OFS][$past(idx_q, 2)*8 +: 8]
                                 == $past(rx_byte, 2))
    else $error("coefficient byte not stored");
  full_cal_c: cover property (st_q == ACC_ST_ZERO ##[1:100] st_q == ACC_ST_RUN);
  recal_c: cover property (ctl_hi_wr && is_cal);
  lo_gain_c: cover property (ctl_wr && idx_q == `ACC_BYTE_LO);
  data_read_c: cover property (rd_last && adr == `ACC_ADDR_DATA && !result_ready_n);
endmodule : acc_calib_regs
`default_nettype wire

//--- acc_cfg.svh
// Offsets, field positions, reset values and encodings of the calibration register block
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
// Serial register addresses
`define ACC_ADDR_DATA 3'h0
`define ACC_ADDR_CTL 3'h1
`define ACC_ADDR_OFS 3'h2
`define ACC_ADDR_POS 3'h3
`define ACC_ADDR_NEG 3'h4
// Coefficient memory word indices
`define ACC_W_OFS 2'h0
`define ACC_W_POS 2'h1
`define ACC_W_NEG 2'h2
// Instruction byte fields
`define ACC_INS_RD 7
`define ACC_INS_CNT_HI 6
`define ACC_INS_CNT_LO 5
`define ACC_INS_IDX_HI 4
`define ACC_INS_IDX_LO 3
`define ACC_INS_ADR_HI 2
// Control byte lanes
`define ACC_BYTE_HI 2'h2
`define ACC_BYTE_MID 2'h1
`define ACC_BYTE_LO 2'h0
// Mode field encodings
`define ACC_MODE_CONV 3'h0
`define ACC_MODE_SELF 3'h1
`define ACC_MODE_SYS_OFS 3'h2
`define ACC_MODE_SYS_GAIN 3'h3
// Control reset: bipolar set, self calibration mode, unity gain
`define ACC_CTL_RESET 24'h000300
`define ACC_GAIN_UNITY 3'h0
// Slope arithmetic: coefficient of 0x400000 means a slope of one
`define ACC_COEF_ONE 24'h400000
`define ACC_COEF_SHIFT 22
`define ACC_IDEAL_FS 24'h7fffff
`define ACC_RES_MAX 24'h7fffff
`define ACC_RES_MIN 24'h800000
`endif

//--- acc_pkg.sv
// Types shared by the calibration register block
`default_nettype none
package acc_pkg;
  typedef struct packed {
    logic coding;
    logic [10:0] filter_code;
    logic [2:0] operating_mode_field;
    logic bipolar;
    logic [2:0] gain_select;
    logic [4:0] misc;
  } acc_ctl_t;
  typedef struct packed {
    logic en;
    logic [1:0] word;
    logic [2:0] lanes;
    logic [23:0] data;
  } acc_wr_t;
  typedef enum logic [1:0] {ACC_PH_INPUT, ACC_PH_ZERO, ACC_PH_POS, ACC_PH_NEG} acc_phase_t;
endpackage : acc_pkg
`default_nettype wire

//--- acc_coef_mem.sv
// Three-word coefficient store with byte-lane writes and registered read-out
`default_nettype none
`include "acc_cfg.svh"
module acc_coef_mem
  import acc_pkg::*;
(
  input wire logic mclk,
  input wire acc_wr_t wr,
  output logic [2:0][23:0] rd_q
);
  logic [2:0][23:0] mem_q;
  logic [2:0][23:0] mem_d;
  // No reset: content is indeterminate until a calibration or host write
  always_comb begin
    mem_d = mem_q;
    for (int b = 0; b < 3; b++) begin
      if (wr.en && wr.lanes[b]) begin
        mem_d[wr.word][b*8 +: 8] = wr.data[b*8 +: 8];
      end
    end
  end
  always_ff @(posedge mclk) begin
    mem_q <= mem_d;
    rd_q <= mem_d;
  end
endmodule : acc_coef_mem
`default_nettype wire

//--- acc_host_model.sv
// Host model that drives the serial register port
`default_nettype none
module acc_host_model (
  input wire logic mclk,
  output logic sclk,
  output logic cs_n,
  output logic sdio,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Data line
  // ----------------------------------------
  logic host_bit;
  // Host toggles its bit while reading, so a stale level never looks like data
  assign sdio = sdio_oe ? sdio_out : host_bit;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    host_bit = 1'b0;
  end
  // ----------------------------------------
  // Frames
  // ----------------------------------------
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask : half
  // Instruction, then n bytes from the top of wdata; clock stands still between frames
  task automatic frame(input logic [7:0] ins, input int n, input logic [23:0] wdata,
                       output logic [23:0] rdata);
    logic [31:0] sh;
    sh = {ins, wdata};
    rdata = 24'h0;
    @(negedge mclk);
    cs_n = 1'b0;
    half();
    for (int i = 0; i < 8 * (n + 1); i++) begin
      sclk = 1'b0;
      host_bit = (i < 8 || !ins[7]) ? sh[31] : ~host_bit;
      sh = sh << 1;
      half();
      sclk = 1'b1;
      half();
      if (i >= 8) begin
        rdata = {rdata[22:0], sdio};
      end
    end
    half();
    cs_n = 1'b1;
    half();
  endtask : frame
endmodule : acc_host_model
`default_nettype wire

//--- acc_calib_regs_tb_top.sv
// Self-checking bench for the calibration register block
`default_nettype none
`include "acc_cfg.svh"
module acc_calib_regs_tb_top
  import acc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic raw_valid = 1'b0;
  logic [23:0] raw_data = 24'h0;
  logic sclk, cs_n, sdio, sdio_out, sdio_oe, result_ready_n;
  logic [2:0] gain_select;
  acc_phase_t cal_phase;
  logic [23:0] rd;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [23:0] OFS = 24'h000100;
  always #10 mclk = ~mclk;
  acc_calib_regs acc_calib_regs_i (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .raw_data(raw_data),
    .raw_valid(raw_valid), .result_ready_n(result_ready_n), .gain_select(gain_select),
    .cal_phase(cal_phase));
  acc_host_model acc_host_model_i (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdio(sdio),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk_flag(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_flag
  task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic sample(input logic [23:0] v);
    @(negedge mclk);
    raw_data = v;
    raw_valid = 1'b1;
    @(negedge mclk);
    raw_valid = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : sample
  task automatic xfer(input logic [7:0] ins, input int n, input logic [23:0] wdata);
    acc_host_model_i.frame(ins, n, wdata, rd);
  endtask : xfer
  // Zero, positive and negative steps; slope coefficients from the span seen
  task automatic run_cal();
    chk_word("phase", {22'h0, ACC_PH_ZERO}, {22'h0, cal_phase});
    sample(OFS);
    chk_word("phase", {22'h0, ACC_PH_POS}, {22'h0, cal_phase});
    sample(24'h600100);
    chk_word("phase", {22'h0, ACC_PH_NEG}, {22'h0, cal_phase});
    sample(24'h900100);
    chk_word("phase", {22'h0, ACC_PH_INPUT}, {22'h0, cal_phase});
    xfer(8'hd2, 3, 24'h0);
    chk_word("offset", OFS, rd);
    xfer(8'hd3, 3, 24'h0);
    chk_word("pos slope", 24'h5fffff, rd);
    xfer(8'hd4, 3, 24'h0);
    chk_word("neg slope", 24'h4fffff, rd);
  endtask : run_cal
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    repeat (16) @(negedge mclk);
    chk_flag("ready", 1'b1, result_ready_n);
    chk_word("gain", 24'h0, {21'h0, gain_select});
    chk_word("phase", {22'h0, ACC_PH_ZERO}, {22'h0, cal_phase});
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    run_cal();
    xfer(8'hd1, 3, 24'h0);
    chk_word("control", 24'h000100, rd);
    $display("test reset done");
  endtask : test_reset
  task automatic test_convert();
    sample(OFS);
    chk_flag("ready", 1'b0, result_ready_n);
    xfer(8'hd0, 3, 24'h0);
    chk_word("zero result", 24'h0, rd);
    chk_flag("ready", 1'b1, result_ready_n);
    xfer(8'h53, 3, `ACC_COEF_ONE);
    sample(OFS + 24'h100000);
    xfer(8'hd0, 3, 24'h0);
    chk_word("unit slope", 24'h100000, rd);
    $display("test convert done");
  endtask : test_convert
  task automatic test_ctl_writes();
    sample(OFS);
    // Low byte only: gain moves but nothing restarts
    xfer(8'h01, 1, {8'ha0, 16'h0});
    chk_flag("ready", 1'b0, result_ready_n);
    chk_word("phase", {22'h0, ACC_PH_INPUT}, {22'h0, cal_phase});
    chk_word("gain", 24'h5, {21'h0, gain_select});
    xfer(8'h51, 3, 24'h0001a0);
    chk_flag("ready", 1'b1, result_ready_n);
    chk_word("phase", {22'h0, ACC_PH_INPUT}, {22'h0, cal_phase});
    sample(OFS);
    chk_flag("ready", 1'b0, result_ready_n);
    xfer(8'h09, 1, {8'h03, 16'h0});
    chk_flag("ready", 1'b1, result_ready_n);
    run_cal();
    chk_word("gain", 24'h5, {21'h0, gain_select});
    $display("test control writes done");
  endtask : test_ctl_writes
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // Whole run needs some 3300 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    test_reset();
    test_convert();
    test_ctl_writes();
    report_and_stop();
  end
endmodule : acc_calib_regs_tb_top
`default_nettype wire
